// ==== hpe_pkg.sv ====
// Package for the error reporting register bank: offsets, field layouts, reset values, carriers.
// Assumes a 12-bit extended configuration address and 32-bit configuration data.
package hpe_pkg;
    localparam int unsigned CFG_ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PTR_W = 5;

    localparam logic [CFG_ADDR_W-1:0] UNCORR_SEVERITY_OFS = 12'h10C;
    localparam logic [CFG_ADDR_W-1:0] CORR_STATUS_OFS = 12'h110;
    localparam logic [CFG_ADDR_W-1:0] CORR_MASK_OFS = 12'h114;

    localparam logic [DATA_W-1:0] SEVERITY_RESET = 32'h0006_2011;
    localparam logic [DATA_W-1:0] SEVERITY_WRITABLE = 32'h001F_F010;
    localparam logic [DATA_W-1:0] SEVERITY_READS_ONE = 32'h0000_0001;
    localparam logic [DATA_W-1:0] CORR_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    // Correctable field positions, shared by status and mask
    localparam int unsigned REPLAY_TIMER_EXPIRED_BIT = 12;
    localparam int unsigned REPLAY_ROLLOVER_BIT = 8;
    localparam int unsigned BAD_LINK_PACKET_BIT = 7;
    localparam int unsigned BAD_TRANSACTION_PACKET_BIT = 6;
    localparam int unsigned RECEIVER_ERROR_BIT = 0;
    localparam int unsigned NUM_CORR = 5;

    // Correctable events, one field per status bit
    typedef struct packed {
        logic replayTimerExpired;
        logic replayRollover;
        logic badLinkPacket;
        logic badTransactionPacket;
        logic receiverError;
    } hpe_cor_evt_t;

    // Messages sent upstream, one-cycle pulses
    typedef struct packed {
        logic fatal;
        logic nonfatal;
        logic correctable;
    } hpe_msg_t;

    // Configuration request and answer
    typedef struct packed {
        logic valid;
        logic write;
        logic [CFG_ADDR_W-1:0] addr;
        logic [3:0] byteEn;
        logic [DATA_W-1:0] wdata;
    } hpe_cfg_req_t;

    typedef struct packed {
        logic ack;
        logic [DATA_W-1:0] rdata;
    } hpe_cfg_rsp_t;
endpackage : hpe_pkg

// ==== hpe_sticky_bit.sv ====
// One correctable status bit with its mask: hardware sets, software writes one to clear.
// Assumes event, clear and write strobes come from logic on the same clock.
`timescale 1ns/1ps
module hpe_sticky_bit
    import hpe_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic syncReset,
    input wire logic errorEvent,
    input wire logic maskBit,
    input wire logic writeOneClear,
    output logic status,
    output logic report
);
    typedef struct packed {
        logic status;
    } hpe_bit_state_t;

    hpe_bit_state_t state;
    hpe_bit_state_t next_state;

    assign report = errorEvent && !maskBit; // R11
    assign status = state.status;

    always_comb begin
        next_state = state;
        if (syncReset) begin
            next_state.status = 1'b0; // R13
        end else if (report) begin
            next_state.status = 1'b1; // R18
        end else if (writeOneClear) begin
            next_state.status = 1'b0; // R5
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule : hpe_sticky_bit

// ==== hpe_aer_regs.sv ====
// Error severity, correctable status and correctable mask registers with message generation.
// Assumes config requests and error events are synchronous to clock; reset pins are not.
//
// What this block does
// R1: Uncorrectable error sends fatal message if severity bit set, else nonfatal.
// R2: Severity register at 10Ch resets to 0006 2011h.
// R3: Severity bits at 20..12 and 4 are writable per error class.
// R4: Severity bit 0 reads one; other reserved bits read zero, ignore writes.
// R5: Correctable status at 110h set by hardware, cleared by writing one.
// R6: Replay timer expiry sets correctable status bit 12.
// R7: Replay counter rollover sets correctable status bit 8.
// R8: Decode error during link packet reception sets bit 7.
// R9: Decode error during transaction packet reception sets bit 6.
// R10: Any decode error sets bit 0.
// R11: Masked error sets no status and sends no message.
// R12: Correctable mask at 114h, same positions, resets to zero.
// R13: Fundamental, global and power-on resets restore all fields.
// R14: Correctable reserved bits read zero and ignore writes.
// R15: Severity bit pairs with uncorrectable status bit at same position.
// R16: Five-bit first error pointer records first uncorrectable class detected.
// R17: Unmasked correctable errors in one cycle send one correctable message between them.
// R18: Hardware set wins over a simultaneous write-one clear.
`timescale 1ns/1ps
module hpe_aer_regs
    import hpe_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic fundamentalReset_b,
    input wire logic global_reset_input_b,
    input wire hpe_cfg_req_t cfgReq,
    output hpe_cfg_rsp_t cfgRsp,
    input wire logic replayTimerExpire,
    input wire logic replayRollover,
    input wire logic decodeError,
    input wire logic rxLinkPacket,
    input wire logic rxTransactionPacket,
    input wire logic [DATA_W-1:0] uncorrEvent,
    input wire logic [DATA_W-1:0] uncorrMask,
    output hpe_msg_t errMsg,
    output logic [PTR_W-1:0] firstErrorPointer,
    output logic firstErrorValid,
    output logic [DATA_W-1:0] severityOut
);
    typedef struct packed {
        logic [1:0] fundSync;
        logic [1:0] globSync;
        logic [DATA_W-1:0] severity;
        logic [DATA_W-1:0] corMask;
        hpe_cfg_rsp_t rsp;
        hpe_msg_t msg;
        logic [PTR_W-1:0] firstPtr;
        logic firstValid;
    } hpe_state_t;

    localparam hpe_state_t STATE_RESET = '{
        fundSync: 2'h0,
        globSync: 2'h0,
        severity: SEVERITY_RESET,
        corMask: CORR_RESET,
        rsp: '0,
        msg: '0,
        firstPtr: 5'h00,
        firstValid: 1'b0
    };

    localparam int unsigned COR_POS [NUM_CORR] = '{
        REPLAY_TIMER_EXPIRED_BIT, REPLAY_ROLLOVER_BIT, BAD_LINK_PACKET_BIT,
        BAD_TRANSACTION_PACKET_BIT, RECEIVER_ERROR_BIT
    };

    hpe_state_t state;
    hpe_state_t next_state;
    hpe_cor_evt_t corEvt;
    logic [NUM_CORR-1:0] corStatus;
    logic [NUM_CORR-1:0] corReport;
    logic [DATA_W-1:0] corStatusWord;
    logic [DATA_W-1:0] corMaskWord;
    logic [DATA_W-1:0] byteMask;
    logic [DATA_W-1:0] w1c;
    logic syncReset;
    logic wrStatus;

    // Reset pins are asynchronous to clock; both levels pass two flops first
    assign syncReset = !state.fundSync[1] || !state.globSync[1]; // R13

    assign corEvt.replayTimerExpired = replayTimerExpire; // R6
    assign corEvt.replayRollover = replayRollover; // R7
    assign corEvt.badLinkPacket = decodeError && rxLinkPacket; // R8
    assign corEvt.badTransactionPacket = decodeError && rxTransactionPacket; // R9
    assign corEvt.receiverError = decodeError; // R10

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            byteMask[b*8 +: 8] = {8{cfgReq.byteEn[b]}};
        end
    end

    assign wrStatus = cfgReq.valid && cfgReq.write && !syncReset && (cfgReq.addr == CORR_STATUS_OFS);
    assign w1c = wrStatus ? (cfgReq.wdata & byteMask) : ZERO_WORD; // R5

    genvar g;
    generate
        for (g = 0; g < NUM_CORR; g++) begin : gCor
            hpe_sticky_bit uBit (
                .clock(clock),
                .rst_b(rst_b),
                .syncReset(syncReset),
                .errorEvent(corEvt[NUM_CORR-1-g]),
                .maskBit(state.corMask[COR_POS[g]]), // R11
                .writeOneClear(w1c[COR_POS[g]]),
                .status(corStatus[g]),
                .report(corReport[g])
            );
        end
    endgenerate

    always_comb begin
        corStatusWord = ZERO_WORD;
        corMaskWord = ZERO_WORD;
        for (int i = 0; i < NUM_CORR; i++) begin
            corStatusWord[COR_POS[i]] = corStatus[i]; // R14
            corMaskWord[COR_POS[i]] = state.corMask[COR_POS[i]]; // R12
        end
    end

    function automatic logic [PTR_W-1:0] lowestSet(input logic [DATA_W-1:0] v);
        logic [PTR_W-1:0] p;
        p = 5'h00;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                p = PTR_W'(i);
            end
        end
        return p;
    endfunction : lowestSet

    always_comb begin
        logic [DATA_W-1:0] uncorrLive;
        uncorrLive = uncorrEvent & ~uncorrMask & SEVERITY_WRITABLE; // R15
        next_state = state;
        next_state.fundSync = {state.fundSync[0], fundamentalReset_b};
        next_state.globSync = {state.globSync[0], global_reset_input_b};
        next_state.rsp.ack = cfgReq.valid;
        next_state.rsp.rdata = ZERO_WORD;
        next_state.msg.fatal = |(uncorrLive & state.severity); // R1
        next_state.msg.nonfatal = |(uncorrLive & ~state.severity); // R1
        next_state.msg.correctable = |corReport; // R17
        if (!state.firstValid && (uncorrLive != ZERO_WORD)) begin
            next_state.firstValid = 1'b1; // R16
            next_state.firstPtr = lowestSet(uncorrLive); // R16
        end
        if (cfgReq.valid && !cfgReq.write) begin
            unique case (cfgReq.addr)
                UNCORR_SEVERITY_OFS: next_state.rsp.rdata =
                    (state.severity & SEVERITY_WRITABLE) | SEVERITY_READS_ONE; // R4
                CORR_STATUS_OFS: next_state.rsp.rdata = corStatusWord; // R14
                CORR_MASK_OFS: next_state.rsp.rdata = corMaskWord; // R14
                default: next_state.rsp.rdata = ZERO_WORD;
            endcase
        end
        if (cfgReq.valid && cfgReq.write) begin
            if (cfgReq.addr == UNCORR_SEVERITY_OFS) begin
                next_state.severity = (state.severity & ~(byteMask & SEVERITY_WRITABLE))
                    | (cfgReq.wdata & byteMask & SEVERITY_WRITABLE); // R3
            end
            if (cfgReq.addr == CORR_MASK_OFS) begin
                for (int i = 0; i < NUM_CORR; i++) begin
                    if (byteMask[COR_POS[i]]) begin
                        next_state.corMask[COR_POS[i]] = cfgReq.wdata[COR_POS[i]]; // R12
                    end
                end
            end
        end
        if (syncReset) begin
            next_state.severity = SEVERITY_RESET; // R2
            next_state.corMask = CORR_RESET; // R13
            next_state.firstPtr = 5'h00;
            next_state.firstValid = 1'b0;
            next_state.msg = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign cfgRsp = state.rsp;
    assign errMsg = state.msg;
    assign firstErrorPointer = state.firstPtr;
    assign firstErrorValid = state.firstValid;
    assign severityOut = (state.severity & SEVERITY_WRITABLE) | SEVERITY_READS_ONE;
endmodule : hpe_aer_regs

// ==== hpe_upstream_model.sv ====
// Upstream port stand-in: counts the error messages it receives.
// Assumes message pulses last one clock cycle.
`timescale 1ns/1ps
module hpe_upstream_model
    import hpe_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire hpe_msg_t errMsg,
    output logic [7:0] fatalCount,
    output logic [7:0] nonfatalCount,
    output logic [7:0] corrCount
);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fatalCount <= 8'h00;
            nonfatalCount <= 8'h00;
            corrCount <= 8'h00;
        end else begin
            fatalCount <= fatalCount + 8'(errMsg.fatal);
            nonfatalCount <= nonfatalCount + 8'(errMsg.nonfatal);
            corrCount <= corrCount + 8'(errMsg.correctable);
        end
    end
endmodule : hpe_upstream_model

// ==== hpe_aer_asserts.sv ====
// Port checker for the error register bank.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module hpe_aer_asserts
    import hpe_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire hpe_cfg_req_t cfgReq,
    input wire hpe_cfg_rsp_t cfgRsp,
    input wire logic replayTimerExpire,
    input wire logic replayRollover,
    input wire logic decodeError,
    input wire logic [DATA_W-1:0] uncorrEvent,
    input wire logic [DATA_W-1:0] uncorrMask,
    input wire hpe_msg_t errMsg,
    input wire logic [PTR_W-1:0] firstErrorPointer,
    input wire logic firstErrorValid,
    input wire logic [DATA_W-1:0] severityOut
);
    logic [DATA_W-1:0] hit;
    logic [DATA_W-1:0] hitQ;
    assign hit = uncorrEvent & ~uncorrMask & SEVERITY_WRITABLE;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) hitQ <= ZERO_WORD;
        else hitQ <= hit;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_sevRead;
        cfgReq.valid && !cfgReq.write && cfgReq.addr == UNCORR_SEVERITY_OFS;
    endsequence
    property p_ack; cfgReq.valid |=> cfgRsp.ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_sevRead; s_sevRead |=> cfgRsp.rdata == $past(severityOut); endproperty
    a_sevRead: assert property (p_sevRead) else $error("severity read");
    property p_sevFixed; (severityOut & ~SEVERITY_WRITABLE) == SEVERITY_READS_ONE; endproperty
    a_sevFixed: assert property (p_sevFixed) else $error("severity fixed bits");
    property p_fatal; |(hit & severityOut) |=> errMsg.fatal; endproperty
    a_fatal: assert property (p_fatal) else $error("fatal missing");
    property p_nonfatal; |(hit & ~severityOut) |=> errMsg.nonfatal; endproperty
    a_nonfatal: assert property (p_nonfatal) else $error("nonfatal missing");
    property p_fatalCause; errMsg.fatal |-> |hitQ; endproperty
    a_fatalCause: assert property (p_fatalCause) else $error("fatal w/o cause");
    property p_corrCause;
        errMsg.correctable |-> $past(decodeError || replayTimerExpire || replayRollover);
    endproperty
    a_corrCause: assert property (p_corrCause) else $error("corr w/o cause");
    property p_ptrFirst; $rose(firstErrorValid) |-> hitQ[firstErrorPointer]; endproperty
    a_ptrFirst: assert property (p_ptrFirst) else $error("pointer wrong");
    property p_ptrHold;
        firstErrorValid && $past(firstErrorValid) |-> $stable(firstErrorPointer);
    endproperty
    a_ptrHold: assert property (p_ptrHold) else $error("pointer moved");
endmodule : hpe_aer_asserts

bind hpe_aer_regs hpe_aer_asserts u_chk (.clock, .rst_b, .cfgReq, .cfgRsp, .replayTimerExpire,
    .replayRollover, .decodeError, .uncorrEvent, .uncorrMask, .errMsg, .firstErrorPointer,
    .firstErrorValid, .severityOut);

// ==== tb.sv ====
// Testbench for the error register bank.
// Assumes the checker is bound in; inputs change at falling edges.
`timescale 1ns/1ps
module tb
    import hpe_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic fundamentalReset_b = 1'b1;
    logic global_reset_input_b = 1'b1;
    hpe_cfg_req_t cfgReq = '0;
    hpe_cfg_rsp_t cfgRsp;
    // Order: timer, rollover, decode, link packet, transaction packet
    logic [4:0] cor = 5'h00;
    logic [DATA_W-1:0] uncorrEvent = ZERO_WORD;
    logic [DATA_W-1:0] uncorrMask = ZERO_WORD;
    hpe_msg_t errMsg;
    logic [PTR_W-1:0] firstErrorPointer;
    logic firstErrorValid;
    logic [DATA_W-1:0] severityOut;
    logic [7:0] fatalCount, nonfatalCount, corrCount;
    int failures = 0;
    int tests_run = 0;
    logic [4:0] corCase [5] = '{5'h10, 5'h08, 5'h06, 5'h05, 5'h04};
    logic [DATA_W-1:0] corExp [5] = '{32'h1000, 32'h100, 32'h81, 32'h41, 32'h1};
    always #25 clock = ~clock;
    hpe_aer_regs dut (.clock, .rst_b, .fundamentalReset_b, .global_reset_input_b, .cfgReq,
        .cfgRsp, .replayTimerExpire(cor[4]), .replayRollover(cor[3]), .decodeError(cor[2]),
        .rxLinkPacket(cor[1]), .rxTransactionPacket(cor[0]), .uncorrEvent, .uncorrMask,
        .errMsg, .firstErrorPointer, .firstErrorValid, .severityOut);
    hpe_upstream_model partner (.clock, .rst_b, .errMsg, .fatalCount, .nonfatalCount,
        .corrCount);
    task summarize;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    task chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
        cfgReq <= '{1'b1, w, a, 4'hF, d};
        @(negedge clock);
        cfgReq.valid <= 1'b0;
        chk({31'h0, cfgRsp.ack}, 32'h1);
        chk(cfgRsp.rdata, e);
        @(negedge clock);
    endtask : acc
    task ev(input logic [4:0] c, input logic [31:0] u, input logic [2:0] m);
        cor <= c;
        uncorrEvent <= u;
        @(negedge clock);
        cor <= 5'h00;
        uncorrEvent <= ZERO_WORD;
        chk({29'h0, errMsg}, {29'h0, m});
        @(negedge clock);
    endtask : ev
    initial begin
        repeat (12) @(negedge clock);
        rst_b = 1'b1;
        repeat (3) @(negedge clock);
        acc(1'b0, UNCORR_SEVERITY_OFS, ZERO_WORD, SEVERITY_RESET);
        acc(1'b0, CORR_STATUS_OFS, ZERO_WORD, CORR_RESET);
        acc(1'b0, CORR_MASK_OFS, ZERO_WORD, CORR_RESET);
        acc(1'b1, 12'h118, 32'hFFFF_FFFF, ZERO_WORD);
        acc(1'b0, 12'h118, ZERO_WORD, ZERO_WORD);
        acc(1'b1, UNCORR_SEVERITY_OFS, 32'hFFFF_FFFF, ZERO_WORD);
        acc(1'b0, UNCORR_SEVERITY_OFS, ZERO_WORD, 32'h001F_F011);
        acc(1'b1, UNCORR_SEVERITY_OFS, ZERO_WORD, ZERO_WORD);
        acc(1'b0, UNCORR_SEVERITY_OFS, ZERO_WORD, 32'h0000_0001);
        // Byte lane 2 disabled: its severity bits must keep their zeros
        cfgReq <= '{1'b1, 1'b1, UNCORR_SEVERITY_OFS, 4'hB, 32'hFFFF_FFFF};
        @(negedge clock);
        cfgReq.valid <= 1'b0;
        @(negedge clock);
        acc(1'b0, UNCORR_SEVERITY_OFS, ZERO_WORD, 32'h0000_F011);
        ev(5'h00, 32'h0004_0000, 3'h2);
        chk({27'h0, firstErrorPointer}, 32'h12);
        acc(1'b1, UNCORR_SEVERITY_OFS, 32'h0004_0000, ZERO_WORD);
        ev(5'h00, 32'h0014_0000, 3'h6);
        chk({27'h0, firstErrorPointer}, 32'h12);
        uncorrMask <= 32'h0004_0000;
        ev(5'h00, 32'h0004_0000, 3'h0);
        uncorrMask <= ZERO_WORD;
        for (int i = 0; i < 5; i++) begin
            ev(corCase[i], ZERO_WORD, 3'h1);
            acc(1'b0, CORR_STATUS_OFS, ZERO_WORD, corExp[i]);
            acc(1'b1, CORR_STATUS_OFS, 32'hFFFF_FFFF, ZERO_WORD);
            acc(1'b0, CORR_STATUS_OFS, ZERO_WORD, CORR_RESET);
        end
        ev(5'h04, ZERO_WORD, 3'h1);
        acc(1'b1, CORR_STATUS_OFS, ZERO_WORD, ZERO_WORD);
        acc(1'b0, CORR_STATUS_OFS, ZERO_WORD, 32'h1);
        // Start the same-edge case from a cleared bit so only the set can leave it high
        acc(1'b1, CORR_STATUS_OFS, 32'h1, ZERO_WORD);
        acc(1'b0, CORR_STATUS_OFS, ZERO_WORD, CORR_RESET);
        // Event and clearing write land on the same edge
        cor <= 5'h04;
        cfgReq <= '{1'b1, 1'b1, CORR_STATUS_OFS, 4'hF, 32'h1};
        @(negedge clock);
        cor <= 5'h00;
        cfgReq.valid <= 1'b0;
        @(negedge clock);
        acc(1'b0, CORR_STATUS_OFS, ZERO_WORD, 32'h1);
        acc(1'b1, CORR_STATUS_OFS, 32'hFFFF_FFFF, ZERO_WORD);
        acc(1'b1, CORR_MASK_OFS, 32'hFFFF_FFFF, ZERO_WORD);
        acc(1'b0, CORR_MASK_OFS, ZERO_WORD, 32'h0000_11C1);
        ev(5'h1F, ZERO_WORD, 3'h0);
        acc(1'b0, CORR_STATUS_OFS, ZERO_WORD, CORR_RESET);
        for (int r = 0; r < 2; r++) begin
            // Leave a status bit set so the reset has something to clear
            acc(1'b1, CORR_MASK_OFS, ZERO_WORD, ZERO_WORD);
            ev(5'h04, ZERO_WORD, 3'h1);
            acc(1'b1, UNCORR_SEVERITY_OFS, ZERO_WORD, ZERO_WORD);
            acc(1'b1, CORR_MASK_OFS, 32'hFFFF_FFFF, ZERO_WORD);
            if (r == 0) fundamentalReset_b <= 1'b0;
            else global_reset_input_b <= 1'b0;
            repeat (3) @(negedge clock);
            fundamentalReset_b <= 1'b1;
            global_reset_input_b <= 1'b1;
            repeat (3) @(negedge clock);
            acc(1'b0, UNCORR_SEVERITY_OFS, ZERO_WORD, SEVERITY_RESET);
            acc(1'b0, CORR_MASK_OFS, ZERO_WORD, CORR_RESET);
            acc(1'b0, CORR_STATUS_OFS, ZERO_WORD, CORR_RESET);
            chk({31'h0, firstErrorValid}, ZERO_WORD);
        end
        chk({24'h0, corrCount}, 32'h9);
        chk({24'h0, fatalCount}, 32'h1);
        chk({24'h0, nonfatalCount}, 32'h2);
        summarize();
    end
    initial begin
        repeat (2000) @(posedge clock);
        failures++;
        summarize();
    end
endmodule : tb
